// ---- core/scratchpad_map.svh ----
// offsets, field positions, sizes and reset values of the scratchpad map
`ifndef SCRATCHPAD_MAP_SVH
`define SCRATCHPAD_MAP_SVH
`define SP_SMALL_DEPTH      9'h040
`define SP_LARGE_DEPTH      9'h088
`define SP_SMALL_SLOT_LOC   8'h3f
`define SP_SLOT_SELECT_LOC  8'h7f
`define SP_MAIN_LOW_LOC     8'h80
`define SP_MAIN_HIGH_LOC    8'h81
`define SP_AUX_LOW_LOC      8'h82
`define SP_AUX_HIGH_LOC     8'h83
`define SP_MODE_LOC         8'h84
`define SP_RUN_SLOT_LOC     8'h85
`define SP_IO_GROUP_LOC     8'h86
`define SP_SUMMARY_LOC      8'h87
`define SP_SUM_OUT_EN_BIT   0
`define SP_SUM_IN_DEF_BIT   1
`define SP_SUM_RUN_EN_BIT   2
`define SP_SUM_LATCH_BIT    3
`define SP_SUM_TRIG_BIT     4
`define SP_SUM_LATCHED_BIT  5
`define SP_SUM_WAIT_BIT     6
`define SP_SUM_ACTIVE_BIT   7
`define SP_BYTE_STEP        8'h01
`define SP_WORD_STEP        8'h02
`define SP_MEM_RESET        8'h00
`define SP_MODE_RESET       4'h0
`define SP_RUN_SLOT_RESET   3'h0
`define SP_UNMAPPED_BYTE    8'h00
`endif

// ---- core/scratchpad_pkg.sv ----
// types shared by the scratchpad status map
package scratchpad_pkg;
	typedef logic [7:0] sp_byte_t;
	typedef struct packed {
		logic [135:0][7:0] mem;
		logic [7:0]        ptr;
		logic [15:0]       rd_data;
		logic              rd_done;
		logic [3:0]        mode;
		logic              out_en;
		logic              run_en;
		logic              latch;
		logic [2:0]        run_slot;
		logic              wait_flag;
	} sp_state_t;
endpackage

// ---- core/scratchpad_ram_status_map.sv ----
// scratchpad memory with read-only slot and polled-interrupt status locations
`timescale 1ns/1ps
`include "scratchpad_map.svh"

// Function
// - a byte read returns the eight-bit value held at the addressed location
// - multi-destination reads walk consecutive locations, one location per byte
// - word reads join two adjacent bytes and advance the pointer by two
// - low nibble of 63 (small) or 127 (large) shows the running slot
// - in the large layout the high nibble of 127 shows the read/write slot
// - memory is reached only through the scratch read and write commands
// - locations 128 to 131 carry per-pin trigger flags, main then auxiliary
// - bits 0-3 of 132 show the last poll mode code written
// - bits 0-2 of 133 show the run slot set by the poll run command
// - bit 0 of 134 shows the active pin group, 1 for auxiliary
// - 135 bits 0, 2, 3 show output enable, run enable, latch mode
// - 135 bit 1 shows an input defined, bit 4 an input triggered
// - 135 bit 5 shows that a polled output signal is latched
// - 135 bit 6 sets on a poll-wait event, cleared only by mode setting
// - 135 bit 7 shows polling active
// - small layout has 64 byte locations, large layout 136
// - every location is readable from whichever slot is running
module scratchpad_ram_status_map
	import scratchpad_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        large_layout,
	input  wire logic        rd_req,
	input  wire logic        rd_first,
	input  wire logic        rd_word,
	input  wire logic [7:0]  rd_addr,
	output logic      [15:0] rd_data,
	output logic             rd_done,
	input  wire logic        wr_req,
	input  wire logic [7:0]  wr_addr,
	input  wire logic [7:0]  wr_data,
	input  wire logic [3:0]  active_slot,
	input  wire logic [3:0]  rw_slot,
	input  wire logic [31:0] trigger_flags,
	input  wire logic        poll_mode_wr,
	input  wire logic [3:0]  poll_mode_code,
	input  wire logic        poll_out_en,
	input  wire logic        poll_run_en,
	input  wire logic        poll_latch_mode,
	input  wire logic        poll_run_wr,
	input  wire logic [2:0]  poll_run_slot,
	input  wire logic        io_group_aux,
	input  wire logic        input_defined,
	input  wire logic        input_triggered,
	input  wire logic        output_latched,
	input  wire logic        poll_wait_event,
	input  wire logic        polling_active
);

	sp_state_t state_reg;
	sp_state_t state_next;

	logic [7:0] rd_base;
	logic [7:0] rd_base_hi;
	sp_byte_t   rd_lo_byte;
	sp_byte_t   rd_hi_byte;
	sp_byte_t   summary_byte;

	// summary of the polling machinery, assembled live at read time
	always_comb
	begin
		summary_byte = `SP_MEM_RESET;
		summary_byte[`SP_SUM_OUT_EN_BIT]  = state_reg.out_en;
		summary_byte[`SP_SUM_IN_DEF_BIT]  = input_defined;
		summary_byte[`SP_SUM_RUN_EN_BIT]  = state_reg.run_en;
		summary_byte[`SP_SUM_LATCH_BIT]   = state_reg.latch;
		summary_byte[`SP_SUM_TRIG_BIT]    = input_triggered;
		summary_byte[`SP_SUM_LATCHED_BIT] = output_latched;
		summary_byte[`SP_SUM_WAIT_BIT]    = state_reg.wait_flag;
		summary_byte[`SP_SUM_ACTIVE_BIT]  = polling_active;
	end

	// one byte of the read map; the status locations come from the poll registers and live inputs, not the memory
	function automatic sp_byte_t map_byte(input logic [7:0] loc);
		sp_byte_t val;
		val = `SP_UNMAPPED_BYTE;
		if (!large_layout)
		begin
			if (loc == `SP_SMALL_SLOT_LOC)
				val = {state_reg.mem[loc][7:4], active_slot};
			else if ({1'b0, loc} < `SP_SMALL_DEPTH)
				val = state_reg.mem[loc];
		end
		else
		begin
			case (loc)
				`SP_SLOT_SELECT_LOC: val = {rw_slot, active_slot};
				`SP_MAIN_LOW_LOC:    val = trigger_flags[7:0];
				`SP_MAIN_HIGH_LOC:   val = trigger_flags[15:8];
				`SP_AUX_LOW_LOC:     val = trigger_flags[23:16];
				`SP_AUX_HIGH_LOC:    val = trigger_flags[31:24];
				`SP_MODE_LOC:        val = {4'h0, state_reg.mode};
				`SP_RUN_SLOT_LOC:    val = {5'h00, state_reg.run_slot};
				`SP_IO_GROUP_LOC:    val = {7'h00, io_group_aux};
				`SP_SUMMARY_LOC:     val = summary_byte;
				default:
				begin
					if (loc < `SP_SLOT_SELECT_LOC)
						val = state_reg.mem[loc];
				end
			endcase
		end
		return val;
	endfunction

	// start of this read: a fresh location, or the running sequential pointer
	always_comb
	begin
		rd_base    = rd_first ? rd_addr : state_reg.ptr;
		rd_base_hi = rd_base + `SP_BYTE_STEP;
		rd_lo_byte = map_byte(rd_base);
		rd_hi_byte = map_byte(rd_base_hi);
	end

	// next state; the memory lives only here, no alias into other storage
	always_comb
	begin
		state_next = state_reg;
		state_next.rd_done = 1'b0;
		// general purpose bytes only; status locations keep their meaning
		if (wr_req)
		begin
			if (!large_layout)
			begin
				if (wr_addr == `SP_SMALL_SLOT_LOC)
					state_next.mem[wr_addr][7:4] = wr_data[7:4];
				else if ({1'b0, wr_addr} < `SP_SMALL_DEPTH)
					state_next.mem[wr_addr] = wr_data;
			end
			else if (wr_addr < `SP_SLOT_SELECT_LOC)
				state_next.mem[wr_addr] = wr_data;
		end
		// reads see the memory as it stood before a write in the same cycle
		if (rd_req)
		begin
			state_next.rd_done = 1'b1;
			if (rd_word)
			begin
				state_next.rd_data = {rd_hi_byte, rd_lo_byte};
				state_next.ptr     = rd_base + `SP_WORD_STEP;
			end
			else
			begin
				state_next.rd_data = {8'h00, rd_lo_byte};
				state_next.ptr     = rd_base + `SP_BYTE_STEP;
			end
		end
		// mode setting also clears the wait flag, but a new event wins
		if (poll_mode_wr)
		begin
			state_next.mode      = poll_mode_code;
			state_next.out_en    = poll_out_en;
			state_next.run_en    = poll_run_en;
			state_next.latch     = poll_latch_mode;
			state_next.wait_flag = 1'b0;
		end
		if (poll_wait_event)
			state_next.wait_flag = 1'b1;
		if (poll_run_wr)
			state_next.run_slot = poll_run_slot;
	end

	// single register stage for all state
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			state_reg.mem       <= '0;
			state_reg.ptr       <= `SP_MEM_RESET;
			state_reg.rd_data   <= 16'h0000;
			state_reg.rd_done   <= 1'b0;
			state_reg.mode      <= `SP_MODE_RESET;
			state_reg.out_en    <= 1'b0;
			state_reg.run_en    <= 1'b0;
			state_reg.latch     <= 1'b0;
			state_reg.run_slot  <= `SP_RUN_SLOT_RESET;
			state_reg.wait_flag <= 1'b0;
		end
		else
			state_reg <= state_next;
	end

	// outputs straight from the state flip-flops
	assign rd_data = state_reg.rd_data;
	assign rd_done = state_reg.rd_done;

	// checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	// reference bytes for the read checks, taken straight from storage
	logic [7:0] chk_lo;
	logic [7:0] chk_hi;
	assign chk_lo = state_reg.mem[rd_addr];
	assign chk_hi = state_reg.mem[rd_base + `SP_BYTE_STEP];

	sequence s_small_slot_read;
		rd_req && rd_first && !rd_word && !large_layout && rd_addr == `SP_SMALL_SLOT_LOC;
	endsequence

	sequence s_large_slot_read;
		rd_req && rd_first && !rd_word && large_layout && rd_addr == `SP_SLOT_SELECT_LOC;
	endsequence

	sequence s_mode_set;
		poll_mode_wr && !poll_wait_event;
	endsequence

	sequence s_read_mode;
		rd_req && rd_first && !rd_word && large_layout && rd_addr == `SP_MODE_LOC;
	endsequence

	sequence s_fresh_byte;
		rd_req && rd_first && !rd_word;
	endsequence

	sequence s_continue;
		rd_req && !rd_first;
	endsequence

	property p_gp_byte_read;
		rd_req && rd_first && !rd_word && large_layout && rd_addr < `SP_SLOT_SELECT_LOC
		|=> rd_done && rd_data == {8'h00, $past(chk_lo)};
	endproperty
	a_gp_byte_read: assert property (p_gp_byte_read)
		else $error("byte read returned wrong value");

	property p_seq_step;
		rd_req && !rd_word |=> state_reg.ptr == $past(rd_base) + `SP_BYTE_STEP;
	endproperty
	a_seq_step: assert property (p_seq_step)
		else $error("byte read did not advance pointer by one");

	property p_word_step;
		rd_req && rd_word |=> state_reg.ptr == $past(rd_base) + `SP_WORD_STEP
			&& rd_data[7:0] == $past(rd_lo_byte);
	endproperty
	a_word_step: assert property (p_word_step)
		else $error("word read did not advance pointer by two");

	property p_small_slot;
		s_small_slot_read |=> rd_data[3:0] == $past(active_slot);
	endproperty
	a_small_slot: assert property (p_small_slot)
		else $error("small layout slot nibble wrong");

	property p_large_slot;
		s_large_slot_read |=> rd_data[7:0] == {$past(rw_slot), $past(active_slot)};
	endproperty
	a_large_slot: assert property (p_large_slot)
		else $error("large layout slot byte wrong");

	property p_trigger_main;
		rd_req && rd_first && !rd_word && large_layout && rd_addr == `SP_MAIN_LOW_LOC
		|=> rd_data == {8'h00, $past(trigger_flags[7:0])};
	endproperty
	a_trigger_main: assert property (p_trigger_main)
		else $error("main low trigger flags wrong");

	property p_mode_readback;
		s_mode_set ##1 (s_read_mode and !poll_mode_wr)
		|=> rd_data[3:0] == $past(poll_mode_code, 2);
	endproperty
	a_mode_readback: assert property (p_mode_readback)
		else $error("poll mode code not reported");

	property p_run_slot;
		poll_run_wr |=> state_reg.run_slot == $past(poll_run_slot);
	endproperty
	a_run_slot: assert property (p_run_slot)
		else $error("run slot not captured");

	property p_wait_set;
		poll_wait_event |=> state_reg.wait_flag;
	endproperty
	a_wait_set: assert property (p_wait_set)
		else $error("wait event lost");

	property p_wait_hold;
		state_reg.wait_flag && !poll_mode_wr |=> state_reg.wait_flag;
	endproperty
	a_wait_hold: assert property (p_wait_hold)
		else $error("wait flag cleared without mode setting");

	property p_wait_clear;
		s_mode_set |=> !state_reg.wait_flag;
	endproperty
	a_wait_clear: assert property (p_wait_clear)
		else $error("mode setting did not clear wait flag");

	property p_small_range;
		rd_req && rd_first && !rd_word && !large_layout && rd_addr[7:6] != 2'b00
		|=> rd_data == 16'h0000;
	endproperty
	a_small_range: assert property (p_small_range)
		else $error("small layout read beyond 64 bytes not zero");

	property p_ro_write;
		wr_req && large_layout && wr_addr >= `SP_SLOT_SELECT_LOC
		|=> state_reg.mem == $past(state_reg.mem);
	endproperty
	a_ro_write: assert property (p_ro_write)
		else $error("write changed a read-only location");

	property p_continue_base;
		s_fresh_byte ##1 s_continue |-> rd_base == $past(rd_addr) + `SP_BYTE_STEP;
	endproperty
	a_continue_base: assert property (p_continue_base)
		else $error("continued read did not start at the next location");

	property p_word_high;
		rd_req && rd_word && large_layout && rd_base < (`SP_SLOT_SELECT_LOC - `SP_BYTE_STEP)
		|=> rd_data[15:8] == $past(chk_hi);
	endproperty
	a_word_high: assert property (p_word_high)
		else $error("word read high byte not from the next location");

	property p_io_group;
		rd_req && !rd_word && large_layout && rd_base == `SP_IO_GROUP_LOC
		|=> rd_data == {15'h0000, $past(io_group_aux)};
	endproperty
	a_io_group: assert property (p_io_group)
		else $error("active pin group bit wrong");

	property p_trigger_aux;
		rd_req && !rd_word && large_layout && rd_base == `SP_AUX_HIGH_LOC
		|=> rd_data == {8'h00, $past(trigger_flags[31:24])};
	endproperty
	a_trigger_aux: assert property (p_trigger_aux)
		else $error("aux high trigger flags wrong");

	property p_large_range;
		rd_req && !rd_word && large_layout && rd_base > `SP_SUMMARY_LOC
		|=> rd_data == 16'h0000;
	endproperty
	a_large_range: assert property (p_large_range)
		else $error("large layout read beyond 136 bytes not zero");

	property p_summary_live;
		rd_req && !rd_word && large_layout && rd_base == `SP_SUMMARY_LOC
		|=> rd_data[`SP_SUM_ACTIVE_BIT] == $past(polling_active)
			&& rd_data[`SP_SUM_LATCHED_BIT] == $past(output_latched)
			&& rd_data[`SP_SUM_TRIG_BIT] == $past(input_triggered)
			&& rd_data[`SP_SUM_IN_DEF_BIT] == $past(input_defined);
	endproperty
	a_summary_live: assert property (p_summary_live)
		else $error("live summary bits wrong");

endmodule

// ---- verif/cmd_core_model.sv ----
// interpreter core model issuing scratchpad read and write commands
`timescale 1ns/1ps
module cmd_core_model
(
	input  wire logic       clock,
	output logic            rd_req,
	output logic            rd_first,
	output logic            rd_word,
	output logic      [7:0] rd_addr,
	output logic            wr_req,
	output logic      [7:0] wr_addr,
	output logic      [7:0] wr_data
);
	// quiet bus at time zero
	initial
	begin
		{rd_req, rd_first, rd_word, wr_req} = 4'h0;
		{rd_addr, wr_addr, wr_data} = 24'h5a5a5a;
	end

	// no edge wait on entry, so calls chain into back-to-back requests
	task automatic rd(input logic f, input logic w, input logic [7:0] a);
		wr_req = 1'b0;
		rd_req = 1'b1;
		rd_first = f;
		rd_word = w;
		rd_addr = a;
		@(posedge clock);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		rd_req = 1'b0;
		wr_req = 1'b1;
		wr_addr = a;
		wr_data = d;
		@(posedge clock);
		#1;
	endtask

	// released lines flip so a stale address can never pass for a live one
	task automatic idle();
		rd_req = 1'b0;
		wr_req = 1'b0;
		rd_addr = ~rd_addr;
		wr_addr = ~wr_addr;
		wr_data = ~wr_data;
		@(posedge clock);
		#1;
	endtask
endmodule

// ---- verif/scratchpad_ram_status_map_tb.sv ----
// self-checking bench for the scratchpad status map
`timescale 1ns/1ps
`include "scratchpad_map.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
	$display("wrong value %s expected %h seen %h", nm, e, g); end end
module scratchpad_ram_status_map_tb
	import scratchpad_pkg::*;
;
	logic        clock, rst, large_layout, rd_done, poll_mode_wr, poll_out_en, poll_run_en;
	logic        poll_latch_mode, poll_run_wr, io_group_aux, input_defined, input_triggered;
	logic        output_latched, poll_wait_event, polling_active, rd_req, rd_first, rd_word;
	logic        wr_req;
	logic [2:0]  poll_run_slot, en;
	logic [3:0]  active_slot, rw_slot, poll_mode_code;
	logic [7:0]  rd_addr, wr_addr, wr_data, seed, s135;
	logic [15:0] rd_data, exp_v;
	logic [31:0] trigger_flags;
	logic [15:0] exp_q[$];
	sp_byte_t    mem[0:135];
	int          n_mismatch = 0, checks_done = 0, cycles = 0;

	cmd_core_model m (.clock(clock), .rd_req(rd_req), .rd_first(rd_first), .rd_word(rd_word),
		.rd_addr(rd_addr), .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data));

	scratchpad_ram_status_map DUT (.clock(clock), .rst(rst), .large_layout(large_layout),
		.rd_req(rd_req), .rd_first(rd_first), .rd_word(rd_word), .rd_addr(rd_addr),
		.rd_data(rd_data), .rd_done(rd_done), .wr_req(wr_req), .wr_addr(wr_addr),
		.wr_data(wr_data), .active_slot(active_slot), .rw_slot(rw_slot),
		.trigger_flags(trigger_flags), .poll_mode_wr(poll_mode_wr),
		.poll_mode_code(poll_mode_code), .poll_out_en(poll_out_en), .poll_run_en(poll_run_en),
		.poll_latch_mode(poll_latch_mode), .poll_run_wr(poll_run_wr),
		.poll_run_slot(poll_run_slot), .io_group_aux(io_group_aux),
		.input_defined(input_defined), .input_triggered(input_triggered),
		.output_latched(output_latched), .poll_wait_event(poll_wait_event),
		.polling_active(polling_active));

	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	// note the expected answer before the request goes out
	task automatic rd(input logic f, input logic w, input logic [7:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		m.rd(f, w, a);
	endtask

	task automatic report_and_stop();
		`CHK("answers outstanding", 0, exp_q.size())
		$display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial
	begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// answers are sampled mid-cycle, well clear of the launching edge
	always @(negedge clock)
	begin
		if (rd_done === 1'b1)
		begin
			if (exp_q.size() == 0)
				`CHK("rd_done", 1'b0, rd_done)
			else
			begin
				exp_v = exp_q.pop_front();
				`CHK("rd_data", exp_v, rd_data)
			end
		end
	end

	// whole run needs well under a thousand cycles
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			n_mismatch++;
			report_and_stop();
		end
	end

	initial
	begin
		{rst, large_layout, poll_mode_wr, poll_run_wr, poll_wait_event} = 5'h18;
		{poll_out_en, poll_run_en, poll_latch_mode, io_group_aux, input_defined} = 5'h00;
		{input_triggered, output_latched, polling_active} = 3'h0;
		{poll_mode_code, poll_run_slot, active_slot, rw_slot} = 15'h0000;
		trigger_flags = 32'h00000000;
		seed = 8'h56;
		repeat (20) @(posedge clock);
		#1;
		rst = 1'b0;
		// fill ordinary locations 20 to 29, then read 25 to 28 back with no gaps
		for (int i = 20; i < 30; i++)
		begin
			seed = lfsr_next(seed);
			mem[i] = seed;
			m.wr(i[7:0], seed);
		end
		rd(1'b1, 1'b0, 8'h19, {8'h00, mem[25]});
		rd(1'b0, 1'b1, 8'h00, {mem[27], mem[26]});
		rd(1'b0, 1'b0, 8'h00, {8'h00, mem[28]});
		active_slot = {1'b0, seed[2:0]};
		rw_slot = {1'b0, seed[6:4]};
		m.wr(`SP_SLOT_SELECT_LOC, 8'hff);
		rd(1'b1, 1'b0, `SP_SLOT_SELECT_LOC, {8'h00, rw_slot, active_slot});
		for (int i = 0; i < 4; i++)
		begin
			seed = lfsr_next(seed);
			trigger_flags[8*i +: 8] = seed;
		end
		for (int i = 0; i < 4; i++)
			rd(i == 0, 1'b0, `SP_MAIN_LOW_LOC, {8'h00, trigger_flags[8*i +: 8]});
		rd(1'b1, 1'b0, 8'hc8, 16'h0000);
		// every mode code; odd codes raise a wait event that the next code clears
		for (int k = 0; k < 16; k++)
		begin
			seed = lfsr_next(seed);
			{polling_active, output_latched, input_triggered, input_defined, io_group_aux} = seed[4:0];
			en = seed[7:5];
			{poll_latch_mode, poll_run_en, poll_out_en} = en;
			poll_mode_code = k[3:0];
			poll_run_slot = k[3:1];
			{poll_mode_wr, poll_run_wr, poll_wait_event} = {2'h3, k[0]};
			m.idle();
			{poll_mode_wr, poll_run_wr, poll_wait_event} = 3'h0;
			{poll_latch_mode, poll_run_en, poll_out_en} = ~en;
			poll_mode_code = ~k[3:0]; // stored copies must not follow the pins
			poll_run_slot = ~k[3:1];
			s135 = {polling_active, k[0], output_latched, input_triggered, en[2:1], input_defined, en[0]};
			rd(1'b1, 1'b0, `SP_MODE_LOC, {12'h000, k[3:0]});
			rd(1'b0, 1'b0, 8'h00, {13'h0000, k[3:1]});
			rd(1'b0, 1'b0, 8'h00, {15'h0000, io_group_aux});
			rd(1'b0, 1'b0, 8'h00, {8'h00, s135});
			rd(1'b1, 1'b0, `SP_SUMMARY_LOC, {8'h00, s135});
		end
		active_slot = {1'b0, ~active_slot[2:0]};
		rd(1'b1, 1'b0, 8'h19, {8'h00, mem[25]});
		// small layout: only the top nibble of the slot location is storage
		large_layout = 1'b0;
		rd(1'b1, 1'b0, 8'h19, {8'h00, mem[25]});
		m.wr(`SP_SMALL_SLOT_LOC, 8'ha5);
		rd(1'b1, 1'b0, `SP_SMALL_SLOT_LOC, {8'h00, 4'ha, active_slot});
		rd(1'b0, 1'b0, 8'h00, 16'h0000);
		rd(1'b1, 1'b0, `SP_SLOT_SELECT_LOC, 16'h0000);
		m.idle();
		m.idle();
		report_and_stop();
	end
endmodule
